// ### hw/dpw_pkg.sv
// package for the dual-port ram write-cycle host controller
// assumes a 100 MHz clock; all pin timing is counted in whole cycles
package dpw_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  // pin timing figures in ns, fastest speed grade
  localparam int T_WC_NS = 15;     // write cycle time
  localparam int T_WP_NS = 12;     // write pulse width
  localparam int T_EW_NS = 12;     // enable to end of write
  localparam int T_DW_NS = 10;     // data valid to end of write
  localparam int T_WZ_NS = 10;     // write enable to output high-z
  localparam int T_HOLD_NS = 0;    // write_data_hold
  localparam int T_WR_NS = 0;      // write recovery
  localparam int T_SWRD_NS = 5;    // flag write to read
  localparam int T_SPS_NS = 5;     // flag contention window
  // least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc
  localparam int MAXI = 32'h7FFFFFFF;
  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2
  // pulse length with output enable low: larger of width and (turn-off + setup)
  localparam int PULSE_OE_CYC = max2(max2(ns2cyc(T_WP_NS), ns2cyc(T_EW_NS)),
                                     ns2cyc(T_WZ_NS) + ns2cyc(T_DW_NS));
  localparam int PULSE_CYC = max2(max2(ns2cyc(T_WP_NS), ns2cyc(T_EW_NS)),
                                  ns2cyc(T_DW_NS));
  localparam int TURNOFF_CYC = ns2cyc(T_WZ_NS);
  localparam int HOLD_CYC = ns2cyc(T_HOLD_NS);
  localparam int CYCLE_CYC = ns2cyc(T_WC_NS);
  localparam int FLAG_GAP_CYC = max2(ns2cyc(T_SWRD_NS), ns2cyc(T_SPS_NS));
  localparam int CNT_W = 4;
  localparam logic [3:0] ONE4 = 4'h1;

  typedef struct packed {
    logic chip_select_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
    logic flag_access_select_n;
    logic write_n;
    logic output_enable_n;
  } dpw_ctl_s;

  typedef struct packed {
    logic is_flag;              // semaphore access instead of array
    logic [1:0] byte_en;        // [1] upper, [0] lower, active high
    logic oe_low;               // keep output enable low during the write
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpw_req_s;

  localparam dpw_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : dpw_pkg

// ### hw/dpw_timer.sv
// down-counter that holds done high once a loaded count runs out
// assumes the loader waits for done before reloading
`timescale 1ns/100ps
module dpw_timer
  import dpw_pkg::*;
(
  input wire logic clk, // 100 MHz
  input wire logic srst, // synchronous, active high
  input wire logic load, // load a new count
  input wire logic [CNT_W-1:0] count, // cycles to run, at least one
  output logic done // high while idle
);
  logic [CNT_W-1:0] cnt_reg;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - ONE4;
    end
  end

  // done looks at the count alone: the sequencer feeds it straight back into load,
  // so gating it with load would close a combinational loop
  assign done = (cnt_reg == '0);
endmodule : dpw_timer

// ### hw/dpw_host.sv
// host-side write controller for one port of an asynchronous dual-port ram
// assumes the ram pins are driven directly from these flip-flops and sampled synchronously
`timescale 1ns/100ps
module dpw_host
  import dpw_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic req_valid, // write request
  output logic req_ready, // request taken when both high
  input wire dpw_req_s req, // request contents
  output logic flag_gap_ok, // high once a flag read may safely follow
  output dpw_ctl_s ctl, // ram control pins, active low
  output logic [ADDR_W-1:0] addr, // ram address pins
  output logic [DATA_W-1:0] dq_o, // ram data out
  output logic dq_oe, // high while host drives data pins
  input wire logic [DATA_W-1:0] dq_i // ram data in, unused on writes
);
  typedef enum logic [2:0] {
    DPW_IDLE, DPW_SETUP, DPW_OFF, DPW_PULSE, DPW_HOLD, DPW_RECOV
  } dpw_state_e;

  dpw_state_e state_reg;
  dpw_req_s req_reg;
  dpw_ctl_s ctl_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] dq_reg;
  logic dq_oe_reg;
  logic gap_reg;
  logic t_load;
  logic [CNT_W-1:0] t_count;
  logic t_done;

  // ---------------------------------------------------------------
  // phase timer
  // ---------------------------------------------------------------
  dpw_timer u_timer (
    .clk(clk),
    .srst(srst),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  assign req_ready = (state_reg == DPW_IDLE) && gap_reg;
  assign ctl = ctl_reg;
  assign addr = addr_reg;
  assign dq_o = dq_reg;
  assign dq_oe = dq_oe_reg;
  assign flag_gap_ok = gap_reg;

  // timer loads on every phase entry except the return to idle
  always_comb begin
    t_load = 1'b0;
    t_count = '0;
    unique case (state_reg)
      DPW_IDLE: begin
        t_load = req_valid && req_ready;
        t_count = CNT_W'(ONE4);
      end
      DPW_SETUP: begin
        t_load = t_done;
        // output enable low: device drivers must turn off first
        t_count = req_reg.oe_low ? CNT_W'(TURNOFF_CYC) : CNT_W'(ONE4);
      end
      DPW_OFF: begin
        t_load = t_done;
        t_count = req_reg.oe_low ? CNT_W'(PULSE_OE_CYC - TURNOFF_CYC)
                                 : CNT_W'(PULSE_CYC);
      end
      DPW_PULSE: begin
        t_load = t_done;
        t_count = CNT_W'(HOLD_CYC);
      end
      DPW_HOLD: begin
        t_load = t_done;
        t_count = CNT_W'(max2(CYCLE_CYC - PULSE_CYC - HOLD_CYC, 1));
      end
      DPW_RECOV: begin
        t_load = 1'b0;
        t_count = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer and pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DPW_IDLE;
      req_reg <= '0;
      ctl_reg <= CTL_IDLE;
      addr_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        DPW_IDLE: if (req_valid && req_ready) begin
          // address moves only while every enable is high
          req_reg <= req;
          addr_reg <= req.addr;
          dq_reg <= req.is_flag ? {DATA_W{req.data[0]}} : req.data;
          ctl_reg.output_enable_n <= !req.oe_low;
          state_reg <= DPW_SETUP;
        end
        DPW_SETUP: if (t_done) begin
          // write line falls first; selects follow so outputs stay off
          ctl_reg.write_n <= 1'b0;
          state_reg <= DPW_OFF;
        end
        DPW_OFF: if (t_done) begin
          // selects fall after write line; data only once device is off
          ctl_reg.chip_select_n <= req_reg.is_flag;
          ctl_reg.flag_access_select_n <= !req_reg.is_flag;
          ctl_reg.upper_byte_select_n <= req_reg.is_flag ? 1'b1 : !req_reg.byte_en[1];
          ctl_reg.lower_byte_select_n <= req_reg.is_flag ? 1'b1 : !req_reg.byte_en[0];
          dq_oe_reg <= 1'b1;
          state_reg <= DPW_PULSE;
        end
        DPW_PULSE: if (t_done) begin
          // end of write: selects and write line rise together
          ctl_reg <= CTL_IDLE;
          state_reg <= DPW_HOLD;
        end
        DPW_HOLD: if (t_done) begin
          dq_oe_reg <= 1'b0;
          state_reg <= DPW_RECOV;
        end
        DPW_RECOV: if (t_done) begin
          state_reg <= DPW_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flag spacing: outcome under contention is never assumed, so wait
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] gap_cnt_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_cnt_reg <= '0;
      gap_reg <= 1'b1;
    end else if (state_reg == DPW_PULSE && t_done && req_reg.is_flag) begin
      gap_cnt_reg <= CNT_W'(FLAG_GAP_CYC);
      gap_reg <= 1'b0;
    end else if (gap_cnt_reg != '0) begin
      gap_cnt_reg <= gap_cnt_reg - ONE4;
      gap_reg <= (gap_cnt_reg == ONE4);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  wire wr_win = !ctl.write_n && !ctl.chip_select_n &&
                !(ctl.upper_byte_select_n && ctl.lower_byte_select_n);

  addr_stable_a: assert property (@(posedge clk) disable iff (srst)
    (!ctl.write_n && !ctl.chip_select_n) |=> $stable(addr))
    else $error("address moved during write");
  sel_after_write_a: assert property (@(posedge clk) disable iff (srst)
    $fell(ctl.chip_select_n) || $fell(ctl.flag_access_select_n) |-> $past(!ctl.write_n))
    else $error("select fell before write line");
  flag_mode_a: assert property (@(posedge clk) disable iff (srst)
    !ctl.flag_access_select_n |-> ctl.chip_select_n)
    else $error("flag and array selected together");
  no_drive_early_a: assert property (@(posedge clk) disable iff (srst)
    $rose(dq_oe) |-> $past(!ctl.write_n, 1) && !ctl.write_n)
    else $error("data driven before turn-off");
  pulse_len_a: assert property (@(posedge clk) disable iff (srst)
    $fell(ctl.write_n) |-> !ctl.write_n [*3])
    else $error("write pulse too short");
  hold_data_a: assert property (@(posedge clk) disable iff (srst)
    $rose(ctl.write_n) |-> dq_oe && $stable(dq_o))
    else $error("data not held at end of write");
  win_only_a: assert property (@(posedge clk) disable iff (srst)
    wr_win |-> dq_oe)
    else $error("write window without data");
  flag_gap_a: assert property (@(posedge clk) disable iff (srst)
    ($rose(ctl.flag_access_select_n)) |-> !flag_gap_ok)
    else $error("flag access not spaced");
  flag_repl_a: assert property (@(posedge clk) disable iff (srst)
    !ctl.flag_access_select_n |-> (dq_o == {DATA_W{dq_o[0]}}))
    else $error("flag value not replicated");

  // address, write end and turn-off margin seen from the pins
  addr_move_a: assert property (@(posedge clk) disable iff (srst)
    !$stable(addr) |-> $past(ctl.write_n || ctl.chip_select_n))
    else $error("address moved inside write window");
  end_together_a: assert property (@(posedge clk) disable iff (srst)
    $rose(ctl.write_n) |-> ctl == CTL_IDLE)
    else $error("enables did not rise together");
  turnoff_wait_a: assert property (@(posedge clk) disable iff (srst)
    $rose(dq_oe) |-> $past(!ctl.write_n, 2))
    else $error("data driven inside turn-off time");

  // main scenarios: both access kinds, both output-enable levels, flag spacing
  array_wr_c: cover property (@(posedge clk) disable iff (srst) wr_win);
  flag_wr_c: cover property (@(posedge clk) disable iff (srst)
    !ctl.flag_access_select_n && !ctl.write_n);
  oe_low_c: cover property (@(posedge clk) disable iff (srst)
    !ctl.write_n && !ctl.output_enable_n);
  oe_high_c: cover property (@(posedge clk) disable iff (srst)
    !ctl.write_n && ctl.output_enable_n);
  gap_wait_c: cover property (@(posedge clk) disable iff (srst) !flag_gap_ok);
endmodule : dpw_host

// ### bench/dpw_ram_model.sv
// behavioural model of one ram port: word array and one flag
// assumes host pins change just after clk rising edges
`timescale 1ns/100ps
module dpw_ram_model
  import dpw_pkg::*;
(
  input wire logic clk, // sampling clock
  input wire dpw_ctl_s ctl, // control pins, active low
  input wire logic [ADDR_W-1:0] addr, // address pins
  input wire logic [DATA_W-1:0] dq_o, // host data
  input wire logic dq_oe, // host drives data
  output logic [DATA_W-1:0] dq_i, // ram data out
  output int viol // host faults seen
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic flag_reg = 1'b1; // released flag reads as ones
  dpw_ctl_s c_q = CTL_IDLE;
  logic [ADDR_W-1:0] a_q = '0;
  logic [DATA_W-1:0] d_q = '0;
  logic [DATA_W-1:0] last_q = '0;
  logic arr_q = 1'b0;
  logic flg_q = 1'b0;
  int viol_q = 0;
  logic arr_win, flg_win, drive;
  initial for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = '0;
  // write windows are the overlap of every enabling condition
  assign arr_win = !ctl.chip_select_n && !ctl.write_n && ctl.flag_access_select_n &&
    (!ctl.upper_byte_select_n || !ctl.lower_byte_select_n);
  assign flg_win = !ctl.flag_access_select_n && !ctl.write_n &&
    (ctl.chip_select_n || (ctl.upper_byte_select_n && ctl.lower_byte_select_n));
  // outputs only on a read; selects falling with or after write_n keep them off
  assign drive = !ctl.output_enable_n && ctl.write_n &&
    (!ctl.chip_select_n || !ctl.flag_access_select_n);
  // released lines show the inverse of the last value, never a stale copy
  assign dq_i = !drive ? ~last_q :
    !ctl.flag_access_select_n ? {DATA_W{flag_reg}} : mem[addr];
  assign viol = viol_q;
  // capture on the first enable rising; one port only, so no contention outcome
  always @(posedge clk) begin
    arr_q <= arr_win;
    flg_q <= flg_win;
    c_q <= ctl;
    a_q <= addr;
    d_q <= dq_o;
    if (drive) last_q <= dq_i;
    if (arr_q && !arr_win) begin
      if (!c_q.upper_byte_select_n) mem[a_q][15:8] <= d_q[15:8];
      if (!c_q.lower_byte_select_n) mem[a_q][7:0] <= d_q[7:0];
    end
    if (flg_q && !flg_win) flag_reg <= d_q[0];
    if ((arr_win && arr_q && addr != a_q) || (drive && dq_oe) || (arr_win && !dq_oe)) begin
      viol_q <= viol_q + 1;
    end
  end
endmodule : dpw_ram_model

// ### bench/testbench.sv
// self-checking bench for the write controller against the ram model
// assumes dpw_pkg, dpw_host and dpw_ram_model are compiled first
`timescale 1ns/100ps
module testbench;
  import dpw_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready, flag_gap_ok, dq_oe;
  dpw_req_s req = '0;
  dpw_ctl_s ctl;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_o, dq_i;
  logic [DATA_W-1:0] shadow [int];
  int viol;
  int bad_count = 0;
  int checks = 0;
  int gap_low = 0;
  // ----------------------------------------
  // clock, design and ram model
  // ----------------------------------------
  always #5 clk = ~clk;
  // flag spacing seen from outside: settled low samples of flag_gap_ok
  always @(negedge clk) if (!srst && flag_gap_ok === 1'b0) gap_low++;
  dpw_host DUT (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .flag_gap_ok(flag_gap_ok), .ctl(ctl), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i));
  dpw_ram_model u_ram (.clk(clk), .ctl(ctl), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i), .viol(viol));
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // bounded wait; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 50) begin
        bad_count++;
        $display("CHECK FAILED req_ready expected 1 seen %b", req_ready);
        finish_test();
      end
    end
  endtask : wait_ready
  task automatic send(input dpw_req_s r);
    wait_ready();
    req = r;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    check("ready after take", 0, req_ready);
    wait_ready();
    @(posedge clk);
    #1;
  endtask : send
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every lane mix, with and without output enable low, each write finished before the next is sent
  task automatic test_array();
    dpw_req_s r;
    logic [DATA_W-1:0] m;
    int g;
    for (int i = 0; i < 8; i++) begin
      r = '0;
      r.byte_en = i[1:0];
      r.oe_low = i[2];
      r.addr = i[0] ? 12'hFFF : 12'h000;
      r.data = 16'hA5C3 ^ 16'(i * 16'h1111);
      m = {{8{r.byte_en[1]}}, {8{r.byte_en[0]}}};
      if (!shadow.exists(r.addr)) shadow[r.addr] = '0;
      shadow[r.addr] = (shadow[r.addr] & ~m) | (r.data & m);
      g = gap_low;
      send(r);
      check("array word", shadow[r.addr], u_ram.mem[r.addr]);
      check("array gap count", 0, gap_low - g);
    end
  endtask : test_array
  // flag writes with both byte selects asked must leave the array alone
  task automatic test_flag();
    dpw_req_s r;
    int g;
    for (int i = 0; i < 2; i++) begin
      r = '0;
      r.is_flag = 1'b1;
      r.byte_en = 2'h3;
      r.data = 16'h1234 ^ 16'(i);
      g = gap_low;
      send(r);
      check("flag value", r.data[0], u_ram.flag_reg);
      check("flag gap count", FLAG_GAP_CYC, gap_low - g);
      check("array untouched", shadow[12'h000], u_ram.mem[0]);
      check("flag gap", 1, flag_gap_ok);
    end
  endtask : test_flag
  // reset in mid-write: pins return to idle and nothing lands in the array
  task automatic test_reset();
    dpw_req_s r;
    r = '0;
    r.byte_en = 2'h3;
    r.addr = 12'h123;
    r.data = 16'h5A5A;
    wait_ready();
    req = r;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("write line low", 0, ctl.write_n);
    srst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("reset pins", CTL_IDLE, ctl);
    check("reset drive", 0, dq_oe);
    check("reset ready", 1, req_ready);
    check("cut write", 0, u_ram.mem[12'h123]);
    srst = 1'b0;
  endtask : test_reset
  initial begin
    repeat (5) @(posedge clk);
    #1;
    check("idle pins", CTL_IDLE, ctl);
    check("data drive", 0, dq_oe);
    srst = 1'b0;
    test_array();
    test_flag();
    test_reset();
    test_array();
    check("host pin faults", 0, viol);
    finish_test();
  end
endmodule : testbench
